// [logic/scaling_bank_regs.svh]
// register indices, field positions, reset values and timing for the scaling bank
`ifndef SCALING_BANK_REGS_SVH
`define SCALING_BANK_REGS_SVH

// register indices; byte address is four times the index
`define IDX_POLE_COMP 14'h2060
`define IDX_SPEED_NUM 14'h2061
`define IDX_SPEED_DEN 14'h2062
`define IDX_ACCEL_NUM 14'h2063
`define IDX_ACCEL_DEN 14'h2064
`define IDX_JERK_NUM 14'h2065
`define IDX_JERK_DEN 14'h2066
`define IDX_BOOT_DELAY 14'h2084
`define IDX_IFACE_AVAIL 14'h2101
`define IDX_IFACE_CTRL 14'h2102
`define IDX_IFACE_COUNT 14'h2103
`define IDX_IFACE_SWITCH 14'h2110
`define IDX_IFACE_ENABLED 14'h2111

// reset values
`define RST_POLE_COMP 32'h00000001
`define RST_SCALE_NUM 32'h00000001
`define RST_SCALE_DEN 32'h0000003c
`define RST_BOOT_DELAY 32'h00000000
`define RST_IFACE_AVAIL 32'h00190001
`define RST_IFACE_CTRL 32'h00080001
`define RST_IFACE_COUNT 8'h02
`define RST_IFACE_SWITCH 32'h00000000
`define RST_IFACE_ENABLED 32'h00080001

// interface bit positions
`define BIT_USB 0
`define BIT_RS485 1
`define BIT_RS232 2
`define BIT_CAN 3
`define BIT_ETHERNET_PORT 4
`define BIT_INDUSTRIAL_ETHERNET_PORT 5
`define BIT_SPI 6
`define BIT_SERIAL_REGISTER_PROTOCOL 16
`define BIT_TCP_REGISTER_PROTOCOL 17
`define BIT_INDUSTRIAL_IP_PROTOCOL 18
`define IFACE_LAYOUT_MASK 32'h0007007f

// timing
`define CLK_PERIOD_NS 40
`define ONE_MS_NS 1000000
`define SCALE_STEPS 7'd71

`endif

// [logic/scaling_bank_pkg.sv]
// types shared by the scaling bank and its scaler
`default_nettype none
package scaling_bank_pkg;

  typedef enum logic [1:0] {
    SC_IDLE = 2'b01,
    SC_DIV = 2'b10
  } scale_phase_type;

  typedef struct packed {
    scale_phase_type phase;
    logic [6:0] count;
    logic [71:0] work;
    logic [32:0] rem;
    logic [31:0] divisor;
    logic [31:0] result;
    logic done;
    logic div_err;
  } scale_state_type;

  typedef struct packed {
    logic [31:0] pole_comp;
    logic [31:0] speed_num;
    logic [31:0] speed_den;
    logic [31:0] accel_num;
    logic [31:0] accel_den;
    logic [31:0] jerk_num;
    logic [31:0] jerk_den;
    logic [31:0] boot_delay;
    logic [31:0] ctrl;
    logic [31:0] enabled;
    logic [31:0] tick;
    logic [31:0] ms_count;
    logic ready;
    logic [31:0] prdata;
    logic pslverr;
  } bank_state_type;

endpackage : scaling_bank_pkg

`default_nettype wire

// [logic/unit_scaler.sv]
// user value times numerator (times pole pairs) over denominator, serial divide
`timescale 1ns/1ps
`default_nettype none
`include "scaling_bank_regs.svh"

module unit_scaler (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [31:0] user_value,
  input wire logic [31:0] numerator,
  input wire logic [31:0] denominator,
  input wire logic compensate,
  input wire logic [7:0] pole_pairs,
  output logic busy,
  output logic done,
  output logic [31:0] result,
  output logic div_err
);

  localparam scaling_bank_pkg::scale_state_type SC_RESET = '{
    phase: scaling_bank_pkg::SC_IDLE, count: 7'h00, work: 72'h0, rem: 33'h0,
    divisor: 32'h0, result: 32'h0, done: 1'b0, div_err: 1'b0};

  scaling_bank_pkg::scale_state_type s_q;
  scaling_bank_pkg::scale_state_type s_d;
  logic [7:0] factor;
  logic [32:0] rem_sh;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    factor = compensate ? pole_pairs : 8'h01;
    rem_sh = {s_q.rem[31:0], s_q.work[71]};
    case (s_q.phase)
      scaling_bank_pkg::SC_IDLE:
      begin
        if (start)
        begin
          if (denominator == 32'h0)
          begin
            // no quotient exists; saturate and flag instead of hanging
            s_d.result = 32'hffffffff;
            s_d.div_err = 1'b1;
            s_d.done = 1'b1;
          end
          else
          begin
            s_d.work = 72'(user_value) * 72'(numerator) * 72'(factor);
            s_d.divisor = denominator;
            s_d.rem = 33'h0;
            s_d.count = `SCALE_STEPS;
            s_d.div_err = 1'b0;
            s_d.phase = scaling_bank_pkg::SC_DIV;
          end
        end
      end
      scaling_bank_pkg::SC_DIV:
      begin
        if (rem_sh >= {1'b0, s_q.divisor})
        begin
          s_d.rem = rem_sh - {1'b0, s_q.divisor};
          s_d.work = {s_q.work[70:0], 1'b1};
        end
        else
        begin
          s_d.rem = rem_sh;
          s_d.work = {s_q.work[70:0], 1'b0};
        end
        s_d.count = s_q.count - 7'd1;
        if (s_q.count == 7'd0)
        begin
          // quotients beyond 32 bits clip rather than wrap
          s_d.result = (s_d.work[71:32] != 40'h0) ? 32'hffffffff : s_d.work[31:0];
          s_d.done = 1'b1;
          s_d.phase = scaling_bank_pkg::SC_IDLE;
        end
      end
      default:
      begin
        s_d = SC_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s_q <= SC_RESET;
    else
      s_q <= s_d;
  end

  assign busy = (s_q.phase == scaling_bank_pkg::SC_DIV);
  assign done = s_q.done;
  assign result = s_q.result;
  assign div_err = s_q.div_err;

  sequence sc_accept_s;
    start && !busy && (denominator != 32'h0);
  endsequence

  sequence sc_finish_s;
    busy [*8] ##65 (done && !busy);
  endsequence

  sc_latency_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    sc_accept_s |=> sc_finish_s)
    else $error("scaler did not finish in 73 cycles");

  sc_zero_den_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    start && !busy && (denominator == 32'h0) |=> done && div_err && (result == 32'hffffffff))
    else $error("zero denominator not flagged");

endmodule : unit_scaler

`default_nettype wire

// [logic/unit_scaling_and_fieldbus_select_regs.sv]
// apb register bank: unit scaling, power-up readiness and interface selection
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scaling_bank_regs.svh"

module unit_scaling_and_fieldbus_select_regs #(
  parameter int MS_CYCLES = `ONE_MS_NS / `CLK_PERIOD_NS,
  parameter logic [31:0] IFACE_AVAIL = `RST_IFACE_AVAIL,
  parameter logic [31:0] IFACE_SWITCH = `RST_IFACE_SWITCH
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] pole_pair_count,
  input wire logic speed_start,
  input wire logic [31:0] speed_value,
  output logic speed_busy,
  output logic speed_done,
  output logic [31:0] speed_result,
  output logic speed_div_err,
  input wire logic accel_start,
  input wire logic [31:0] accel_value,
  output logic accel_busy,
  output logic accel_done,
  output logic [31:0] accel_result,
  output logic accel_div_err,
  input wire logic jerk_start,
  input wire logic [31:0] jerk_value,
  output logic jerk_busy,
  output logic jerk_done,
  output logic [31:0] jerk_result,
  output logic jerk_div_err,
  output logic pole_comp_active,
  output logic device_ready,
  output logic [31:0] iface_enabled
);

  localparam scaling_bank_pkg::bank_state_type BANK_RESET = '{
    pole_comp: `RST_POLE_COMP,
    speed_num: `RST_SCALE_NUM,
    speed_den: `RST_SCALE_DEN,
    accel_num: `RST_SCALE_NUM,
    accel_den: `RST_SCALE_DEN,
    jerk_num: `RST_SCALE_NUM,
    jerk_den: `RST_SCALE_DEN,
    boot_delay: `RST_BOOT_DELAY,
    ctrl: `RST_IFACE_CTRL,
    enabled: `RST_IFACE_ENABLED,
    tick: 32'h0,
    ms_count: 32'h0,
    ready: 1'b0,
    prdata: 32'h0,
    pslverr: 1'b0};

  // only bits that exist in the layout can ever be switched
  localparam logic [31:0] SWITCH_MASK = IFACE_SWITCH & `IFACE_LAYOUT_MASK;
  // availability is reported as built, protocol bits beyond the table included
  localparam logic [31:0] AVAIL_WORD = IFACE_AVAIL;
  localparam logic [31:0] MS_LAST = 32'(MS_CYCLES - 1);

  scaling_bank_pkg::bank_state_type s_q;
  scaling_bank_pkg::bank_state_type s_d;
  logic [13:0] idx;
  logic setup_ph;
  logic wr_acc;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_ok;
  logic comp_on;

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    logic [31:0] m;
    m = old_word;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        m[8*i +: 8] = new_word[8*i +: 8];
    end
    return m;
  endfunction : merge_bytes

  assign idx = paddr[15:2];
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign comp_on = (s_q.pole_comp == 32'h00000001);

  // read mux and decode; writable registers mark wr_ok
  always_comb
  begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    wr_ok = 1'b0;
    case (idx)
      `IDX_POLE_COMP:
      begin
        rd_word = s_q.pole_comp;
        wr_ok = 1'b1;
      end
      `IDX_SPEED_NUM:
      begin
        rd_word = s_q.speed_num;
        wr_ok = 1'b1;
      end
      `IDX_SPEED_DEN:
      begin
        rd_word = s_q.speed_den;
        wr_ok = 1'b1;
      end
      `IDX_ACCEL_NUM:
      begin
        rd_word = s_q.accel_num;
        wr_ok = 1'b1;
      end
      `IDX_ACCEL_DEN:
      begin
        rd_word = s_q.accel_den;
        wr_ok = 1'b1;
      end
      `IDX_JERK_NUM:
      begin
        rd_word = s_q.jerk_num;
        wr_ok = 1'b1;
      end
      `IDX_JERK_DEN:
      begin
        rd_word = s_q.jerk_den;
        wr_ok = 1'b1;
      end
      `IDX_BOOT_DELAY:
      begin
        rd_word = s_q.boot_delay;
        wr_ok = 1'b1;
      end
      `IDX_IFACE_AVAIL: rd_word = AVAIL_WORD;
      `IDX_IFACE_CTRL:
      begin
        rd_word = s_q.ctrl;
        wr_ok = 1'b1;
      end
      `IDX_IFACE_COUNT: rd_word = {24'h0, `RST_IFACE_COUNT};
      `IDX_IFACE_SWITCH: rd_word = SWITCH_MASK;
      `IDX_IFACE_ENABLED: rd_word = s_q.enabled;
      default: rd_hit = 1'b0;
    endcase
    if (paddr[1:0] != 2'b00)
    begin
      rd_hit = 1'b0;
      wr_ok = 1'b0;
    end
  end

  always_comb
  begin
    s_d = s_q;
    // answer is prepared in the setup cycle so prdata leaves a flop
    if (setup_ph)
    begin
      s_d.prdata = (rd_hit && !pwrite) ? rd_word : 32'h0;
      s_d.pslverr = !rd_hit || (pwrite && !wr_ok);
    end
    if (wr_acc && wr_ok)
    begin
      case (idx)
        `IDX_POLE_COMP: s_d.pole_comp = merge_bytes(s_q.pole_comp, pwdata, pstrb);
        `IDX_SPEED_NUM: s_d.speed_num = merge_bytes(s_q.speed_num, pwdata, pstrb);
        `IDX_SPEED_DEN: s_d.speed_den = merge_bytes(s_q.speed_den, pwdata, pstrb);
        `IDX_ACCEL_NUM: s_d.accel_num = merge_bytes(s_q.accel_num, pwdata, pstrb);
        `IDX_ACCEL_DEN: s_d.accel_den = merge_bytes(s_q.accel_den, pwdata, pstrb);
        `IDX_JERK_NUM: s_d.jerk_num = merge_bytes(s_q.jerk_num, pwdata, pstrb);
        `IDX_JERK_DEN: s_d.jerk_den = merge_bytes(s_q.jerk_den, pwdata, pstrb);
        `IDX_BOOT_DELAY: s_d.boot_delay = merge_bytes(s_q.boot_delay, pwdata, pstrb);
        `IDX_IFACE_CTRL:
        begin
          s_d.ctrl = merge_bytes(s_q.ctrl, pwdata, pstrb);
          // fixed interfaces keep their state whatever is written
          s_d.enabled = (s_q.enabled & ~SWITCH_MASK) | (s_d.ctrl & SWITCH_MASK);
        end
        default: s_d.ctrl = s_q.ctrl;
      endcase
    end
    // millisecond timebase since reset release, saturating
    if (s_q.tick == MS_LAST)
    begin
      s_d.tick = 32'h0;
      if (s_q.ms_count != 32'hffffffff)
        s_d.ms_count = s_q.ms_count + 32'h1;
    end
    else
    begin
      s_d.tick = s_q.tick + 32'h1;
    end
    // once ready, a later delay write cannot withdraw readiness
    s_d.ready = s_q.ready || (s_q.ms_count >= s_q.boot_delay);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s_q <= BANK_RESET;
    else
      s_q <= s_d;
  end

  assign pready = psel && penable;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign device_ready = s_q.ready;
  assign iface_enabled = s_q.enabled;
  assign pole_comp_active = comp_on;

  unit_scaler speed_scaler (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(speed_start),
    .user_value(speed_value),
    .numerator(s_q.speed_num),
    .denominator(s_q.speed_den),
    .compensate(comp_on),
    .pole_pairs(pole_pair_count),
    .busy(speed_busy),
    .done(speed_done),
    .result(speed_result),
    .div_err(speed_div_err)
  );

  unit_scaler accel_scaler (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(accel_start),
    .user_value(accel_value),
    .numerator(s_q.accel_num),
    .denominator(s_q.accel_den),
    .compensate(comp_on),
    .pole_pairs(pole_pair_count),
    .busy(accel_busy),
    .done(accel_done),
    .result(accel_result),
    .div_err(accel_div_err)
  );

  unit_scaler jerk_scaler (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(jerk_start),
    .user_value(jerk_value),
    .numerator(s_q.jerk_num),
    .denominator(s_q.jerk_den),
    .compensate(comp_on),
    .pole_pairs(pole_pair_count),
    .busy(jerk_busy),
    .done(jerk_done),
    .result(jerk_result),
    .div_err(jerk_div_err)
  );

  default clocking bank_cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  ctrl_reset_a: assert property (
    !$past(rstn) |-> (s_q.ctrl == `RST_IFACE_CTRL) && (iface_enabled == `RST_IFACE_ENABLED))
    else $error("control word reset value wrong");

  speed_reset_a: assert property (
    !$past(rstn) |-> (s_q.speed_num == `RST_SCALE_NUM) && (s_q.speed_den == `RST_SCALE_DEN))
    else $error("speed scale reset value wrong");

  boot_ready_a: assert property (
    $rose(device_ready) |-> ($past(s_q.ms_count) >= $past(s_q.boot_delay)))
    else $error("ready before boot delay elapsed");

  ready_hold_a: assert property (
    device_ready |=> device_ready)
    else $error("readiness withdrawn");

  fixed_iface_a: assert property (
    1'b1 |=> ((iface_enabled & ~SWITCH_MASK) == ($past(iface_enabled) & ~SWITCH_MASK)))
    else $error("non-switchable interface changed");

  ctrl_follow_a: assert property (
    wr_acc && (idx == `IDX_IFACE_CTRL) && (paddr[1:0] == 2'b00) && (pstrb == 4'hf)
    |=> ((iface_enabled & SWITCH_MASK) == ($past(pwdata) & SWITCH_MASK)))
    else $error("enabled status did not follow control write");

  avail_read_a: assert property (
    psel && penable && !pwrite && (paddr == {`IDX_IFACE_AVAIL, 2'b00})
    |-> (prdata == AVAIL_WORD) && !pslverr)
    else $error("availability word read wrong");

  count_read_a: assert property (
    psel && penable && !pwrite && (paddr == {`IDX_IFACE_COUNT, 2'b00})
    |-> (prdata == 32'h00000002))
    else $error("entry count read wrong");

  layout_bits_a: assert property (
    (iface_enabled & ~`IFACE_LAYOUT_MASK) == (`RST_IFACE_ENABLED & ~`IFACE_LAYOUT_MASK))
    else $error("enabled bit outside layout changed");

  ro_write_a: assert property (
    psel && penable && pwrite && (paddr == {`IDX_IFACE_AVAIL, 2'b00}) |-> pslverr)
    else $error("write to read-only word not refused");

  switch_read_a: assert property (
    psel && penable && !pwrite && (paddr == {`IDX_IFACE_SWITCH, 2'b00})
    |-> (prdata == SWITCH_MASK) && !pslverr)
    else $error("switchable mask read wrong");

  enabled_read_a: assert property (
    psel && penable && !pwrite && (paddr == {`IDX_IFACE_ENABLED, 2'b00})
    |-> (prdata == $past(iface_enabled)) && !pslverr)
    else $error("enabled status read wrong");

  speed_write_a: assert property (
    wr_acc && (idx == `IDX_SPEED_NUM) && (paddr[1:0] == 2'b00) && (pstrb == 4'hf)
    |=> (s_q.speed_num == $past(pwdata)))
    else $error("speed numerator write lost");

endmodule : unit_scaling_and_fieldbus_select_regs

`default_nettype wire

// [dv/test_unit_scaling_and_fieldbus_select_regs.sv]
// self-checking bench for the scaling and interface selection register bank
`timescale 1ns/1ps
`default_nettype none
`include "scaling_bank_regs.svh"

`define CHK(g, e) \
  begin \
    checks_done = checks_done + 1; \
    if ((g) !== (e)) \
    begin \
      err_total = err_total + 1; \
      $display("Error at %0t ns: got %h expected %h", $time, (g), (e)); \
    end \
  end

module test_unit_scaling_and_fieldbus_select_regs;
  // usb and rs-232 switchable; bit 19 stays fixed so its enable must survive writes
  localparam logic [31:0] SWITCH = 32'h00000005;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hf;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  logic [7:0] pole_pairs = 8'h32;
  logic [2:0] start_v = 3'h0;
  logic [31:0] value_v [0:2] = '{32'h0, 32'h0, 32'h0};
  wire logic [2:0] busy_v;
  wire logic [2:0] done_v;
  wire logic [2:0] err_v;
  wire logic [31:0] result_v [0:2];
  wire logic comp_on;
  wire logic ready;
  wire logic [31:0] enabled;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] rd;
  logic er;

  always #20 ref_clk = ~ref_clk;

  unit_scaling_and_fieldbus_select_regs #(.MS_CYCLES(10), .IFACE_SWITCH(SWITCH)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pole_pair_count(pole_pairs),
    .speed_start(start_v[0]), .speed_value(value_v[0]), .speed_busy(busy_v[0]),
    .speed_done(done_v[0]), .speed_result(result_v[0]), .speed_div_err(err_v[0]),
    .accel_start(start_v[1]), .accel_value(value_v[1]), .accel_busy(busy_v[1]),
    .accel_done(done_v[1]), .accel_result(result_v[1]), .accel_div_err(err_v[1]),
    .jerk_start(start_v[2]), .jerk_value(value_v[2]), .jerk_busy(busy_v[2]),
    .jerk_done(done_v[2]), .jerk_result(result_v[2]), .jerk_div_err(err_v[2]),
    .pole_comp_active(comp_on), .device_ready(ready), .iface_enabled(enabled)
  );

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic [13:0] idx, input logic wr, input logic [31:0] wd,
                     input logic [3:0] sb);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= sb;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n = n + 1;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(n < 20, 1'b1)
  endtask : apb

  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp, input logic exp_er);
    apb(idx, 1'b0, 32'h00000000, 4'hf);
    `CHK(rd, exp)
    `CHK(er, exp_er)
  endtask : rd_chk

  task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
    apb(idx, 1'b1, wd, 4'hf);
  endtask : wr

  // start pulse, then a bounded wait for the done pulse
  task automatic scale(input int k, input logic [31:0] val, input logic [31:0] exp,
                       input logic exp_err);
    int n;
    n = 0;
    @(posedge ref_clk);
    start_v[k] <= 1'b1;
    value_v[k] <= val;
    @(posedge ref_clk);
    start_v[k] <= 1'b0;
    while (done_v[k] !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      n = n + 1;
      if (n == 1)
        `CHK(busy_v[k], !exp_err)
    end
    `CHK(n < 100, 1'b1)
    `CHK(n, exp_err ? 1 : int'(`SCALE_STEPS) + 2)
    `CHK(busy_v[k], 1'b0)
    `CHK(result_v[k], exp)
    `CHK(err_v[k], exp_err)
  endtask : scale

  task automatic test_reset_values();
    rd_chk(`IDX_POLE_COMP, 32'h00000001, 1'b0);
    rd_chk(`IDX_SPEED_NUM, 32'h00000001, 1'b0);
    rd_chk(`IDX_SPEED_DEN, 32'h0000003c, 1'b0);
    rd_chk(`IDX_ACCEL_NUM, 32'h00000001, 1'b0);
    rd_chk(`IDX_ACCEL_DEN, 32'h0000003c, 1'b0);
    rd_chk(`IDX_JERK_NUM, 32'h00000001, 1'b0);
    rd_chk(`IDX_JERK_DEN, 32'h0000003c, 1'b0);
    rd_chk(`IDX_BOOT_DELAY, 32'h00000000, 1'b0);
    rd_chk(`IDX_IFACE_AVAIL, 32'h00190001, 1'b0);
    rd_chk(`IDX_IFACE_CTRL, 32'h00080001, 1'b0);
    rd_chk(`IDX_IFACE_COUNT, 32'h00000002, 1'b0);
    rd_chk(`IDX_IFACE_SWITCH, SWITCH, 1'b0);
    rd_chk(`IDX_IFACE_ENABLED, 32'h00080001, 1'b0);
    rd_chk(14'h2067, 32'h00000000, 1'b1);
    `CHK(ready, 1'b1)
    $display("test reset values done");
  endtask : test_reset_values

  task automatic test_access();
    wr(`IDX_SPEED_NUM, 32'h0000aaaa);
    apb(`IDX_SPEED_NUM, 1'b1, 32'h00005500, 4'h2);
    rd_chk(`IDX_SPEED_NUM, 32'h000055aa, 1'b0);
    wr(`IDX_SPEED_NUM, 32'h00000001);
    apb(`IDX_IFACE_AVAIL, 1'b1, 32'hffffffff, 4'hf);
    `CHK(er, 1'b1)
    rd_chk(`IDX_IFACE_AVAIL, 32'h00190001, 1'b0);
    apb(`IDX_IFACE_COUNT, 1'b1, 32'h00000007, 4'hf);
    `CHK(er, 1'b1)
    rd_chk(`IDX_IFACE_COUNT, 32'h00000002, 1'b0);
    $display("test access done");
  endtask : test_access

  task automatic test_iface_switch();
    // usb off, rs-232 on, bit 19 cleared but not switchable
    wr(`IDX_IFACE_CTRL, 32'h00000004);
    rd_chk(`IDX_IFACE_CTRL, 32'h00000004, 1'b0);
    rd_chk(`IDX_IFACE_ENABLED, 32'h00080004, 1'b0);
    `CHK(enabled, 32'h00080004)
    wr(`IDX_IFACE_CTRL, 32'hffffffff);
    rd_chk(`IDX_IFACE_ENABLED, 32'h00080005, 1'b0);
    `CHK(enabled, 32'h00080005)
    $display("test interface switching done");
  endtask : test_iface_switch

  task automatic test_scaling();
    `CHK(comp_on, 1'b1)
    scale(0, 32'd1200, 32'd1000, 1'b0);
    wr(`IDX_POLE_COMP, 32'h00000000);
    @(posedge ref_clk);
    `CHK(comp_on, 1'b0)
    scale(0, 32'd1200, 32'd20, 1'b0);
    wr(`IDX_ACCEL_NUM, 32'h00000003);
    wr(`IDX_ACCEL_DEN, 32'h00000007);
    scale(1, 32'd100, 32'd42, 1'b0);
    wr(`IDX_JERK_DEN, 32'h00000000);
    scale(2, 32'd5, 32'hffffffff, 1'b1);
    wr(`IDX_JERK_DEN, 32'h00000002);
    wr(`IDX_POLE_COMP, 32'h00000001);
    scale(2, 32'd4, 32'd100, 1'b0);
    $display("test scaling done");
  endtask : test_scaling

  initial
  begin
    repeat (8) @(posedge ref_clk);
    `CHK(ready, 1'b0)
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    test_reset_values();
    test_access();
    test_iface_switch();
    test_scaling();
    repeat (2) @(posedge ref_clk);
    wrap_up();
  end

  // the whole run needs well under 2000 cycles
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    err_total = err_total + 1;
    wrap_up();
  end
endmodule : test_unit_scaling_and_fieldbus_select_regs
`default_nettype wire
